/* logic/vic_pkg.sv */
// Shared constants, register map and state types of the interrupt controller
package vic_pkg;

  // ******************************************************************
  // Program counter and vectors
  // ******************************************************************
  localparam int PC_W = 12;
  localparam logic [PC_W-1:0] VEC_EXT = 12'h004;
  localparam logic [PC_W-1:0] VEC_TMR0 = 12'h008;
  localparam logic [PC_W-1:0] VEC_TMR1 = 12'h00C;
  localparam int NUM_SRC = 3;

  // ******************************************************************
  // Register map (byte addresses) and field positions
  // ******************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam int BIT_GIE = 0;
  localparam int BIT_EXT_EN = 1;
  localparam int BIT_TMR0_EN = 2;
  localparam int BIT_TMR1_EN = 3;
  localparam int BIT_EXT_FLAG = 4;
  localparam int BIT_TMR0_FLAG = 5;
  localparam int BIT_TMR1_FLAG = 6;
  localparam int BIT_ST_PDOWN = 0;
  localparam int BIT_ST_STACK = 1;
  localparam int BIT_ST_PEND = 2;
  localparam int POS_ST_SRC = 4;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

  // ******************************************************************
  // State types
  // ******************************************************************
  typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} vic_bus_t;

  typedef struct packed {
    vic_bus_t bus;
    logic waitreq;
    logic [31:0] rdata;
    logic gie;
    logic [NUM_SRC-1:0] en;
    logic [NUM_SRC-1:0] flag;
    logic ph_prev;
    logic take;
    logic [PC_W-1:0] vector;
    logic [PC_W-1:0] push_pc;
    logic pop;
    logic wake;
    logic [1:0] last_src;
  } vic_state_t;

  localparam vic_state_t ST_RESET = '{bus: BUS_IDLE, waitreq: 1'b1,
      rdata: RDATA_NONE, gie: 1'b0, en: 3'h0, flag: 3'h0, ph_prev: 1'b0,
      take: 1'b0, vector: 12'h000, push_pc: 12'h000, pop: 1'b0,
      wake: 1'b0, last_src: 2'h0};

  // Vector address of a source index, lowest index first in priority
  function automatic logic [PC_W-1:0] vic_vector(input logic [1:0] idx);
    case (idx)
      2'h0: vic_vector = VEC_EXT;
      2'h1: vic_vector = VEC_TMR0;
      default: vic_vector = VEC_TMR1;
    endcase
  endfunction

endpackage

/* logic/vic_pin_edge.sv */
// Pin synchroniser with high-to-low transition detector
module vic_pin_edge
  import vic_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pin,
  output logic o_fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } vic_edge_t;

  vic_edge_t st;
  vic_edge_t next_st;

  // Released pin idles high, so reset to high avoids a false edge
  always_comb begin
    next_st = st;
    next_st.s1 = i_pin;
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  assign o_fall = st.prev & ~st.s2;

endmodule

/* logic/vic_prio.sv */
// Fixed priority selection among enabled pending sources
module vic_prio
  import vic_pkg::*;
(
  input wire logic [NUM_SRC-1:0] i_req,
  output logic o_valid,
  output logic [1:0] o_idx
);

  always_comb begin
    o_valid = |i_req;
    o_idx = 2'h2;
    if (i_req[0]) begin
      o_idx = 2'h0;
    end else if (i_req[1]) begin
      o_idx = 2'h1;
    end
  end

endmodule

/* logic/vic_core.sv */
// Interrupt controller: flags, enables, priority, entry and wake-up
//
// Our own choices: the address map and the Avalon-MM slave port.
module vic_core
  import vic_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_ext_pin,
  input wire logic i_port_g_dir_bit0,
  input wire logic i_tmr0_ovf,
  input wire logic i_tmr1_ovf,
  input wire logic i_clock_phase_two,
  input wire logic i_stack_full,
  input wire logic i_reti,
  input wire logic i_power_down,
  input wire logic [PC_W-1:0] i_next_pc,
  output logic o_irq_take,
  output logic [PC_W-1:0] o_vector,
  output logic [PC_W-1:0] o_push_pc,
  output logic o_pc_pop,
  output logic o_wake
);

  // ******************************************************************
  // Elaboration checks
  // ******************************************************************
  generate
    if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr
      $error("vic_core: ADDR_W must be 3 to 8");
    end
  endgenerate

  // ******************************************************************
  // Sources
  // ******************************************************************
  vic_state_t st;
  vic_state_t next_st;
  logic ext_fall;
  logic [NUM_SRC-1:0] set_evt;
  logic [NUM_SRC-1:0] ready_req;
  logic sel_valid;
  logic [1:0] sel_idx;
  logic ph_rise;
  logic do_take;
  logic req;
  logic wr_ctrl;
  logic [7:0] addr8;
  logic [7:0] ctrl_byte;
  logic [7:0] status_byte;

  vic_pin_edge u_pin_edge (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_ext_pin),
    .o_fall(ext_fall)
  );

  // Pin counts only while it is configured as interrupt input
  assign set_evt[0] = ext_fall & st.en[0] & i_port_g_dir_bit0;
  assign set_evt[1] = i_tmr0_ovf;
  assign set_evt[2] = i_tmr1_ovf;

  assign ready_req = st.flag & st.en;

  vic_prio u_prio (
    .i_req(ready_req),
    .o_valid(sel_valid),
    .o_idx(sel_idx)
  );

  // The sequencer phase is on our clock, so no synchroniser is needed
  assign ph_rise = i_clock_phase_two & ~st.ph_prev;
  // Stack full keeps the flag pending instead of losing it
  // Global enable gates every source
  assign do_take = ph_rise & st.gie & sel_valid & ~i_stack_full;

  // ******************************************************************
  // Register bus
  // ******************************************************************
  assign req = i_read | i_write;
  assign addr8 = 8'(i_address);
  assign wr_ctrl = i_write & st.waitreq & (addr8 == OFS_CTRL) &
      i_byteenable[0];

  always_comb begin
    ctrl_byte = 8'h00;
    ctrl_byte[BIT_GIE] = st.gie;
    ctrl_byte[BIT_EXT_EN] = st.en[0];
    ctrl_byte[BIT_TMR0_EN] = st.en[1];
    ctrl_byte[BIT_TMR1_EN] = st.en[2];
    ctrl_byte[BIT_EXT_FLAG] = st.flag[0];
    ctrl_byte[BIT_TMR0_FLAG] = st.flag[1];
    ctrl_byte[BIT_TMR1_FLAG] = st.flag[2];
    status_byte = 8'h00;
    status_byte[BIT_ST_PDOWN] = i_power_down;
    status_byte[BIT_ST_STACK] = i_stack_full;
    status_byte[BIT_ST_PEND] = sel_valid;
    status_byte[POS_ST_SRC +: 2] = st.last_src;
  end

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    next_st = st;
    next_st.ph_prev = i_clock_phase_two;
    next_st.take = 1'b0;
    next_st.pop = i_reti;
    next_st.wake = 1'b0;

    // One wait cycle, then the answer stands for the completing edge
    case (st.bus)
      BUS_IDLE: begin
        if (req) begin
          next_st.bus = BUS_ACK;
          next_st.waitreq = 1'b0;
          next_st.rdata = RDATA_NONE;
          if (i_read && addr8 == OFS_CTRL) begin
            next_st.rdata = {24'h00_0000, ctrl_byte};
          end else if (i_read && addr8 == OFS_STATUS) begin
            next_st.rdata = {24'h00_0000, status_byte};
          end
        end
      end
      BUS_ACK: begin
        next_st.bus = BUS_IDLE;
        next_st.waitreq = 1'b1;
      end
      default: begin
        next_st.bus = BUS_IDLE;
        next_st.waitreq = 1'b1;
      end
    endcase

    // Software write first, hardware clear next, hardware set last
    if (wr_ctrl) begin
      next_st.gie = i_writedata[BIT_GIE];
      next_st.en[0] = i_writedata[BIT_EXT_EN];
      next_st.en[1] = i_writedata[BIT_TMR0_EN];
      next_st.en[2] = i_writedata[BIT_TMR1_EN];
      next_st.flag[0] = i_writedata[BIT_EXT_FLAG];
      next_st.flag[1] = i_writedata[BIT_TMR0_FLAG];
      next_st.flag[2] = i_writedata[BIT_TMR1_FLAG];
    end

    if (do_take) begin
      next_st.take = 1'b1;
      // Entry clear beats a software set in the same cycle
      next_st.gie = 1'b0;
      next_st.flag[sel_idx] = 1'b0;
      next_st.vector = vic_vector(sel_idx);
      // Only the return address is handed over for pushing
      next_st.push_pc = i_next_pc;
      next_st.last_src = sel_idx;
    end

    // A new event always wins over any clear of its flag
    next_st.flag = next_st.flag | set_evt;

    // Timer wake ignores its enable; an already set flag masks it
    if (i_power_down && (((set_evt[1] | set_evt[2]) &
        ~(st.flag[1] | st.flag[2]) & (set_evt[1] ? ~st.flag[1] : 1'b1)) ||
        (set_evt[2] && !st.flag[2]) || (set_evt[1] && !st.flag[1]) ||
        set_evt[0])) begin
      next_st.wake = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign o_readdata = st.rdata;
  assign o_waitrequest = st.waitreq;
  assign o_irq_take = st.take;
  assign o_vector = st.vector;
  assign o_push_pc = st.push_pc;
  assign o_pc_pop = st.pop;
  assign o_wake = st.wake;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  logic past_gie;
  logic past_full;
  logic past_rise;
  logic past_ext_rdy;
  logic past_t0_rdy;
  logic [NUM_SRC-1:0] past_set;
  logic [NUM_SRC-1:0] past_take_clr;
  logic past_wr;
  logic [PC_W-1:0] past_pc;

  always_ff @(posedge i_clk) begin
    past_gie <= st.gie;
    past_full <= i_stack_full;
    past_rise <= ph_rise;
    past_ext_rdy <= ready_req[0];
    past_t0_rdy <= ready_req[1];
    past_set <= set_evt;
    past_take_clr <= do_take ? (3'h1 << sel_idx) : 3'h0;
    past_wr <= wr_ctrl;
    past_pc <= i_next_pc;
  end

  sequence s_bus_req;
    st.bus == BUS_IDLE && req;
  endsequence

  sequence s_bus_answer;
    !o_waitrequest ##1 o_waitrequest;
  endsequence

  sequence s_entry;
    $rose(o_irq_take) && !st.gie;
  endsequence

  a_take_needs_gie: assert property (@(posedge i_clk)
      disable iff (!i_reset_n) o_irq_take |-> past_gie && !past_full)
    else $error("interrupt taken without global enable or with full stack");

  a_entry_clears_gie: assert property (@(posedge i_clk)
      disable iff (!i_reset_n) o_irq_take |-> s_entry)
    else $error("global enable not cleared on entry");

  a_take_on_phase: assert property (@(posedge i_clk)
      disable iff (!i_reset_n) o_irq_take |-> past_rise)
    else $error("interrupt taken away from a phase two rising edge");

  a_prio_order: assert property (@(posedge i_clk)
      disable iff (!i_reset_n)
      o_irq_take && o_vector != VEC_EXT |-> !past_ext_rdy &&
      (o_vector == VEC_TMR0 || !past_t0_rdy))
    else $error("lower priority source served before a higher one");

  a_push_next_pc: assert property (@(posedge i_clk)
      disable iff (!i_reset_n) o_irq_take |-> o_push_pc == past_pc)
    else $error("pushed address is not the next instruction address");

  a_flag_cleared: assert property (@(posedge i_clk)
      disable iff (!i_reset_n)
      o_irq_take && o_vector == VEC_EXT && !past_set[0] |-> !st.flag[0])
    else $error("external flag not cleared on service");

  a_flag_holds: assert property (@(posedge i_clk)
      disable iff (!i_reset_n)
      $fell(st.flag[1]) |-> past_take_clr[1] || past_wr)
    else $error("timer 0 flag dropped without service or software clear");

  a_set_wins: assert property (@(posedge i_clk)
      disable iff (!i_reset_n) set_evt[2] |=> st.flag[2])
    else $error("timer 1 overflow lost");

  a_reti_pop: assert property (@(posedge i_clk)
      disable iff (!i_reset_n) i_reti |=> o_pc_pop)
    else $error("return did not pop the program counter");

  a_timer_wake: assert property (@(posedge i_clk)
      disable iff (!i_reset_n)
      i_power_down && i_tmr0_ovf && !st.flag[1] |=> o_wake)
    else $error("timer 0 overflow did not wake from power down");

  a_bus_answer: assert property (@(posedge i_clk)
      disable iff (!i_reset_n) s_bus_req |=> s_bus_answer)
    else $error("bus answer not given after one wait cycle");

endmodule

/* testbench/vic_cpu_model.sv */
// Program sequencer model: phase two, program counter and return stack
module vic_cpu_model
  import vic_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_take,
  input wire logic [PC_W-1:0] i_vector,
  input wire logic [PC_W-1:0] i_push_pc,
  input wire logic i_ret_req,
  output logic o_phase,
  output logic [PC_W-1:0] o_next_pc,
  output logic o_stack_full,
  output logic o_reti
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PC_W-1:0] stk [DEPTH];
  logic [1:0] cyc;
  int depth;
  // Phase two rises once every four system clocks
  assign o_phase = cyc[1];
  assign o_stack_full = (depth >= DEPTH);
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      cyc <= 2'h0;
      depth <= 0;
      o_reti <= 1'b0;
      o_next_pc <= 12'h020;
    end else begin
      cyc <= cyc + 2'h1;
      o_reti <= i_ret_req && (depth > 0);
      if (i_take) begin
        stk[depth] <= i_push_pc;
        depth <= depth + 1;
        o_next_pc <= i_vector + 12'h001;
      end else if (o_reti) begin
        depth <= depth - 1;
        o_next_pc <= stk[depth-1];
      end else begin
        o_next_pc <= o_next_pc + 12'h001;
      end
    end
  end
endmodule

/* testbench/vectored_interrupt_control_tb.sv */
// Self-checking bench of the interrupt controller with a sequencer model
module vectored_interrupt_control_tb
  import vic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_reset_n, i_read, i_write, i_ext_pin, i_tmr0_ovf;
  logic i_tmr1_ovf, i_power_down, ret_req, ph, full, reti, ph1, ph2, reti1;
  logic dir;
  logic o_waitrequest, o_irq_take, o_pc_pop, o_wake;
  logic [3:0] i_address;
  logic [31:0] i_writedata, o_readdata, rd;
  logic [PC_W-1:0] o_vector, o_push_pc, npc, pc1;
  logic [PC_W-1:0] vecs [3] = '{VEC_EXT, VEC_TMR0, VEC_TMR1};
  int err_count, n_tests, cyc, takes, wakes, xw, pops, rets, t0, gie, en, fl;

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  vic_core u_vic_core (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(4'hf), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_ext_pin(i_ext_pin),
    .i_port_g_dir_bit0(dir), .i_tmr0_ovf(i_tmr0_ovf),
    .i_tmr1_ovf(i_tmr1_ovf), .i_clock_phase_two(ph), .i_stack_full(full),
    .i_reti(reti), .i_power_down(i_power_down), .i_next_pc(npc),
    .o_irq_take(o_irq_take), .o_vector(o_vector), .o_push_pc(o_push_pc),
    .o_pc_pop(o_pc_pop), .o_wake(o_wake));

  vic_cpu_model #(.DEPTH(2)) u_vic_cpu_model (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_take(o_irq_take), .i_vector(o_vector),
    .i_push_pc(o_push_pc), .i_ret_req(ret_req), .o_phase(ph),
    .o_next_pc(npc), .o_stack_full(full), .o_reti(reti));

  // ****************************************************************
  // Tasks and reference model
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [31:0] ctrl();
    return 32'(gie + en * 2 + fl * 16);
  endfunction

  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_write <= wr;
    i_read <= !wr;
    i_writedata <= d;
    // Only the bench timeout ends a wait that never completes
    do begin
      @(posedge i_clk);
    end while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    if (wr && a == OFS_CTRL[3:0]) begin
      gie = int'(d[0]);
      en = int'(d[3:1]);
      fl = int'(d[6:4]);
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  // Ext edge latches only with its enable; a timer wakes only if flag clear
  task automatic ev(input int s);
    if (i_power_down && (s == 0 ? en % 2 == 1 : ((fl >> s) & 1) == 0)) xw++;
    if (s > 0 || en % 2 == 1) fl |= 1 << s;
    @(posedge i_clk);
    if (s == 0) i_ext_pin <= 1'b0;
    else if (s == 1) i_tmr0_ovf <= 1'b1;
    else i_tmr1_ovf <= 1'b1;
    @(posedge i_clk);
    i_tmr0_ovf <= 1'b0;
    i_tmr1_ovf <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_ext_pin <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask

  task automatic wait_take;
    int k, s;
    s = (fl & en & 1) != 0 ? 0 : ((fl & en & 2) != 0 ? 1 : 2);
    k = 0;
    while (o_irq_take !== 1'b1 && k < 40) begin
      @(posedge i_clk);
      k++;
    end
    chk({o_irq_take, 19'h0, o_vector}, {1'b1, 19'h0, vecs[s]});
    fl &= ~(1 << s);
    gie = 0;
  endtask

  task automatic retire;
    @(posedge i_clk);
    ret_req <= 1'b1;
    @(posedge i_clk);
    ret_req <= 1'b0;
    rets++;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (o_irq_take === 1'b1) begin
      takes++;
      chk({ph2, ph1, 18'h0, o_push_pc}, {2'b01, 18'h0, pc1});
    end
    if (o_wake === 1'b1) wakes++;
    if (o_pc_pop === 1'b1) begin
      pops++;
      chk({31'h0, reti1}, 32'h0000_0001);
    end
    ph2 = ph1;
    ph1 = ph;
    pc1 = npc;
    reti1 = reti;
    // Whole run needs about three hundred cycles
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    i_reset_n = 1'b0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 4'h0;
    i_writedata = 32'h0000_0000;
    i_ext_pin = 1'b1;
    i_tmr0_ovf = 1'b0;
    i_tmr1_ovf = 1'b0;
    i_power_down = 1'b0;
    ret_req = 1'b0;
    dir = 1'b1;
    void'($urandom(65237));
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rdchk(OFS_CTRL[3:0], 32'h0000_0000);
    rdchk(4'h8, 32'h0000_0000);
    repeat (4) begin
      bus(1'b1, OFS_CTRL[3:0], $urandom & 32'h0000_007e);
      repeat (8) @(posedge i_clk);
      rdchk(OFS_CTRL[3:0], ctrl());
    end
    chk(32'(takes), 32'h0000_0000);
    // Pin set as output: its falling edge must not latch the flag
    dir <= 1'b0;
    bus(1'b1, OFS_CTRL[3:0], 32'h0000_0002);
    en = 0;
    ev(0);
    en = 1;
    rdchk(OFS_CTRL[3:0], ctrl());
    dir <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      bus(1'b1, OFS_CTRL[3:0], 32'(2 << s));
      ev(s);
      rdchk(OFS_CTRL[3:0], ctrl());
      bus(1'b1, OFS_CTRL[3:0], ctrl() | 32'h0000_0001);
      wait_take();
      rdchk(OFS_CTRL[3:0], ctrl());
      retire();
    end
    bus(1'b1, OFS_CTRL[3:0], 32'h0000_007e);
    bus(1'b1, OFS_CTRL[3:0], 32'h0000_007f);
    wait_take();
    bus(1'b1, OFS_CTRL[3:0], ctrl() | 32'h0000_0001);
    wait_take();
    bus(1'b1, OFS_CTRL[3:0], ctrl() | 32'h0000_0001);
    t0 = takes;
    repeat (20) @(posedge i_clk);
    chk(32'(takes - t0), 32'h0000_0000);
    rdchk(OFS_STATUS[3:0], 32'h0000_0016);
    retire();
    wait_take();
    retire();
    retire();
    repeat (4) @(posedge i_clk);
    i_power_down <= 1'b1;
    bus(1'b1, OFS_CTRL[3:0], 32'h0000_0002);
    for (int s = 0; s < 3; s++) ev(s);
    ev(1);
    chk(32'(wakes), 32'(xw));
    chk(32'(pops), 32'(rets));
    wrap_up();
  end
endmodule
